// >>> src/casc_timer_pkg.sv
// constants for the cascaded 16-bit timer / event counter
// assumes a 32-bit classic wishbone slave port, byte addresses
package casc_timer_pkg;
  // register byte offsets
  localparam logic [4:0] OFS_COUNT  = 5'h00;
  localparam logic [4:0] OFS_CMP    = 5'h04;
  localparam logic [4:0] OFS_CLKSEL = 5'h08;
  localparam logic [4:0] OFS_MODE   = 5'h0c;
  localparam logic [4:0] OFS_OUTCTL = 5'h10;
  localparam logic [4:0] OFS_OSC    = 5'h14;
  localparam logic [4:0] OFS_STAT   = 5'h18;
  // field positions
  localparam int CE_BIT      = 0;  // count_enable_bit
  localparam int CASC_BIT    = 2;  // cascade_mode_bit
  localparam int HIGH_OUTPUT_ENABLE_BIT    = 4;  // high_output_enable
  localparam int DIVSEL_BIT  = 0;  // oscillator_divide_select
  localparam int ST_LOW_IRQ  = 0;  // low_match_irq flag
  localparam int ST_CASC_IRQ = 1;  // cascade_match_irq flag
  localparam int ST_FF1      = 2;  // output flip-flop 1
  localparam int ST_FF2      = 3;  // square wave flip-flop
  // reset values
  localparam logic [7:0] RST_BYTE   = 8'h00;
  localparam logic [3:0] RST_CLKSEL = 4'h0;
  // clock select codes
  localparam logic [3:0] SEL_EV_FALL = 4'h0;
  localparam logic [3:0] SEL_EV_RISE = 4'h1;
  localparam logic [3:0] SEL_INT_LO  = 4'h6;
  localparam logic [3:0] SEL_INT_TOP = 4'hf;
  // period exponents with divide select set
  localparam int EXP_LO_BASE = 1;   // code 6 gives 2^1
  localparam int EXP_TOP     = 11;  // code f gives 2^11
  localparam int PRE_W       = 12;  // prescaler width
  // clock period of clk_i, taken as the osc period
  localparam int CLK_PERIOD_NS = 10;
  // least square pulse width in osc periods
  localparam int MIN_PULSE_PERIODS = 2;
endpackage : casc_timer_pkg

// >>> src/casc_timer.sv
// cascaded 16-bit timer / event counter with wishbone registers
// assumes clk_i is the main oscillator; event pin synchronous
`timescale 1ns/100ps
`default_nettype none
module casc_timer
  import casc_timer_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [4:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // pins and requests
  input  wire logic        event_input_pin_i,
  output logic             square_wave_pin_o,
  output logic             low_match_irq_o,
  output logic             cascade_match_irq_o
);

  // period exponent for a code; zero means no internal clock
  // codes 6 to e climb one octave each, code f jumps to the top
  // a clear divide select adds one octave to every period
  // event codes and prohibited codes both return zero here
  function automatic int unsigned period_exp(input logic [3:0] code,
                                             input logic       dsel);
    int unsigned e;
    e = 0;
    if (code == SEL_INT_TOP) begin
      e = EXP_TOP;
    end else if (code >= SEL_INT_LO) begin
      e = EXP_LO_BASE + 32'(code - SEL_INT_LO);
    end
    if (e != 0 && !dsel) begin
      e = e + 1;
    end
    return e;
  endfunction : period_exp

  // registers
  // everything below is cleared by the synchronous reset
  // counts clear when stopped and otherwise move only on a tick; flags set on a tick
  logic [7:0]       low_count_register_r, low_count_register_nxt;
  logic [7:0]       high_count_register_r, high_count_register_nxt;
  logic [7:0]       low_compare_register_r, low_compare_register_nxt;
  logic [7:0]       high_compare_register_r, high_compare_register_nxt;
  logic [3:0]       count_clock_select_reg_r, count_clock_select_reg_nxt;
  logic [7:0]       timer_mode_control_reg_r, timer_mode_control_reg_nxt;
  logic [7:0]       output_control_reg_r, output_control_reg_nxt;
  logic             osc_div_sel_r, osc_div_sel_nxt;
  logic             low_flag_r, low_flag_nxt;      // sticky low match
  logic             casc_flag_r, casc_flag_nxt;    // sticky full match
  logic             ff1_r, ff1_nxt;                // output ff 1
  logic             ff2_r, ff2_nxt;                // square wave ff
  logic             low_irq_r, low_irq_nxt;        // request pulse
  logic             casc_irq_r, casc_irq_nxt;      // request pulse
  logic [PRE_W-1:0] pre_r, pre_nxt;                // free prescaler
  logic             ev_d_r, ev_d_nxt;              // last event level
  logic             ack_r, ack_nxt;
  logic [31:0]      dat_r, dat_nxt;

  // decoded controls
  logic        run;          // counting allowed
  logic        tick;         // one count clock
  logic        ev_rise;
  logic        ev_fall;
  logic        low_match;
  logic        full_match;
  logic        bus_req;
  logic        wr;
  logic [15:0] count16;
  int unsigned exp_sel;

  // count clock generation
  // the event sample flop resets low, matching the idle pin level,
  // so release of reset never looks like an edge
  // internal ticks fall where the low prescaler bits are all ones
  always_comb begin
    exp_sel = period_exp(count_clock_select_reg_r, osc_div_sel_r);
    ev_rise = event_input_pin_i & ~ev_d_r;
    ev_fall = ~event_input_pin_i & ev_d_r;
    pre_nxt = pre_r + 1'b1;
    ev_d_nxt = event_input_pin_i;
    case (count_clock_select_reg_r)
      SEL_EV_FALL: tick = ev_fall;
      SEL_EV_RISE: tick = ev_rise;
      default: begin
        if (exp_sel != 0) begin
          tick = (pre_r & PRE_W'((1 << exp_sel) - 1))
                 == PRE_W'((1 << exp_sel) - 1);
        end else begin
          // prohibited codes never count
          tick = 1'b0;
        end
      end
    endcase
  end

  // bus decode
  // ack_r blocks a second take of a strobe that is still held
  // read data is latched with ack so it stands for that cycle
  always_comb begin
    bus_req = wb_cyc_i & wb_stb_i & ~ack_r;
    wr      = bus_req & wb_we_i;
    ack_nxt = bus_req;
    count16 = {high_count_register_r, low_count_register_r};
    dat_nxt = dat_r;
    if (bus_req && !wb_we_i) begin
      case (wb_adr_i)
        OFS_COUNT:  dat_nxt = {16'h0000, count16};
        OFS_CMP:    dat_nxt = {16'h0000, high_compare_register_r,
                               low_compare_register_r};
        OFS_CLKSEL: dat_nxt = {28'h0000000, count_clock_select_reg_r};
        OFS_MODE:   dat_nxt = {24'h000000, timer_mode_control_reg_r};
        OFS_OUTCTL: dat_nxt = {24'h000000, output_control_reg_r};
        OFS_OSC:    dat_nxt = {31'h00000000, osc_div_sel_r};
        OFS_STAT:   dat_nxt = {28'h0000000, ff2_r, ff1_r,
                               casc_flag_r, low_flag_r};
        // unmapped reads as zero
        default:    dat_nxt = 32'h00000000;
      endcase
    end
  end

  // register writes
  always_comb begin
    low_compare_register_nxt   = low_compare_register_r;
    high_compare_register_nxt  = high_compare_register_r;
    count_clock_select_reg_nxt = count_clock_select_reg_r;
    timer_mode_control_reg_nxt = timer_mode_control_reg_r;
    output_control_reg_nxt     = output_control_reg_r;
    osc_div_sel_nxt            = osc_div_sel_r;
    if (wr) begin
      case (wb_adr_i)
        OFS_CMP: begin
          if (wb_sel_i[0]) begin
            low_compare_register_nxt = wb_dat_i[7:0];
          end
          if (wb_sel_i[1]) begin
            high_compare_register_nxt = wb_dat_i[15:8];
          end
        end
        OFS_CLKSEL: begin
          if (wb_sel_i[0]) begin
            count_clock_select_reg_nxt = wb_dat_i[3:0];
          end
        end
        OFS_MODE: begin
          if (wb_sel_i[0]) begin
            timer_mode_control_reg_nxt = wb_dat_i[7:0];
          end
        end
        OFS_OUTCTL: begin
          if (wb_sel_i[0]) begin
            output_control_reg_nxt = wb_dat_i[7:0];
          end
        end
        OFS_OSC: begin
          if (wb_sel_i[0]) begin
            osc_div_sel_nxt = wb_dat_i[DIVSEL_BIT];
          end
        end
        // count is read only, status is write-one clear in the flag logic, others ignored
        default: begin
        end
      endcase
    end
  end

  // counting, match and flag logic
  // the count is compared before it moves, so a compare of zero
  // matches on the first tick after start
  // a stopped counter is held at zero for a clean restart
  always_comb begin
    run = timer_mode_control_reg_r[CE_BIT] &
          timer_mode_control_reg_r[CASC_BIT];
    low_match  = low_count_register_r == low_compare_register_r;
    full_match = low_match &
                 (high_count_register_r == high_compare_register_r);
    low_count_register_nxt  = low_count_register_r;
    high_count_register_nxt = high_count_register_r;
    ff1_nxt      = ff1_r;
    ff2_nxt      = ff2_r;
    low_irq_nxt  = 1'b0;
    casc_irq_nxt = 1'b0;
    if (!run) begin
      // stopped: counters held clear
      low_count_register_nxt  = RST_BYTE;
      high_count_register_nxt = RST_BYTE;
    end else if (tick) begin
      if (low_match) begin
        low_irq_nxt = 1'b1;
        ff1_nxt     = ~ff1_r;
      end
      if (full_match) begin
        low_count_register_nxt  = RST_BYTE;
        high_count_register_nxt = RST_BYTE;
        casc_irq_nxt            = 1'b1;
        if (output_control_reg_r[HIGH_OUTPUT_ENABLE_BIT]) begin
          ff2_nxt = ~ff2_r;
        end
      end else begin
        low_count_register_nxt = low_count_register_r + 8'h01;
        if (low_count_register_r == 8'hff) begin
          high_count_register_nxt = high_count_register_r + 8'h01;
        end
      end
    end
    // sticky flags: set wins over write-one clear
    // a request and a clear in one cycle leave the flag set,
    // so software never loses an event that lands on its clear
    low_flag_nxt  = low_flag_r;
    casc_flag_nxt = casc_flag_r;
    if (wr && wb_adr_i == OFS_STAT && wb_sel_i[0]) begin
      if (wb_dat_i[ST_LOW_IRQ]) begin
        low_flag_nxt = 1'b0;
      end
      if (wb_dat_i[ST_CASC_IRQ]) begin
        casc_flag_nxt = 1'b0;
      end
    end
    if (low_irq_nxt) begin
      low_flag_nxt = 1'b1;
    end
    if (casc_irq_nxt) begin
      casc_flag_nxt = 1'b1;
    end
  end

  // state registers
  // one register bank; all next values come from the blocks above
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      low_count_register_r     <= RST_BYTE;
      high_count_register_r    <= RST_BYTE;
      low_compare_register_r   <= RST_BYTE;
      high_compare_register_r  <= RST_BYTE;
      count_clock_select_reg_r <= RST_CLKSEL;
      timer_mode_control_reg_r <= RST_BYTE;
      output_control_reg_r     <= RST_BYTE;
      osc_div_sel_r            <= 1'b0;
      low_flag_r               <= 1'b0;
      casc_flag_r              <= 1'b0;
      ff1_r                    <= 1'b0;
      ff2_r                    <= 1'b0;
      low_irq_r                <= 1'b0;
      casc_irq_r               <= 1'b0;
      pre_r                    <= '0;
      ev_d_r                   <= 1'b0;
      ack_r                    <= 1'b0;
      dat_r                    <= 32'h00000000;
    end else begin
      low_count_register_r     <= low_count_register_nxt;
      high_count_register_r    <= high_count_register_nxt;
      low_compare_register_r   <= low_compare_register_nxt;
      high_compare_register_r  <= high_compare_register_nxt;
      count_clock_select_reg_r <= count_clock_select_reg_nxt;
      timer_mode_control_reg_r <= timer_mode_control_reg_nxt;
      output_control_reg_r     <= output_control_reg_nxt;
      osc_div_sel_r            <= osc_div_sel_nxt;
      low_flag_r               <= low_flag_nxt;
      casc_flag_r              <= casc_flag_nxt;
      ff1_r                    <= ff1_nxt;
      ff2_r                    <= ff2_nxt;
      low_irq_r                <= low_irq_nxt;
      casc_irq_r               <= casc_irq_nxt;
      pre_r                    <= pre_nxt;
      ev_d_r                   <= ev_d_nxt;
      ack_r                    <= ack_nxt;
      dat_r                    <= dat_nxt;
    end
  end

  // outputs straight from flops
  // no logic between these flops and the pins
  // requests are one-cycle pulses; sticky copies live in status
  assign wb_ack_o            = ack_r;
  assign wb_dat_o            = dat_r;
  assign square_wave_pin_o   = ff2_r;
  assign low_match_irq_o     = low_irq_r;
  assign cascade_match_irq_o = casc_irq_r;

endmodule : casc_timer
`default_nettype wire

// >>> bench/casc_timer_assertions.sv
// checker: bus and match relations at the timer ports
// assumes the package is compiled first; bound at the foot
`timescale 1ns/100ps
`default_nettype none
module casc_timer_chk
  import casc_timer_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [4:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        square_wave_pin_o,
  input wire logic        low_match_irq_o,
  input wire logic        cascade_match_irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // bus answers one cycle after taking
  AST_ACK_NEXT: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  AST_ACK_ONE: assert property (
    wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  AST_ACK_CAUSE: assert property (
    wb_ack_o |-> $past(wb_stb_i)) else $error("ack without strobe");
  // count word: high byte over low byte, top half zero
  AST_CNT_HI: assert property (
    wb_ack_o && !wb_we_i && wb_adr_i == OFS_COUNT
    |-> wb_dat_o[31:16] == 16'h0) else $error("count word top not zero");
  // full match always carries a low match
  AST_CASC_LOW: assert property (
    cascade_match_irq_o |-> low_match_irq_o)
    else $error("cascade request without low request");
  AST_CASC_ONE: assert property (
    cascade_match_irq_o |=> !cascade_match_irq_o)
    else $error("cascade request too long");
  // ticks are at least two periods apart
  AST_LOW_GAP: assert property (
    low_match_irq_o |=> !low_match_irq_o) else $error("low requests adjacent");
  // square pin moves only with a full match
  AST_SQ_TOGGLE: assert property (
    $changed(square_wave_pin_o) |-> cascade_match_irq_o)
    else $error("square pin moved without match");
  COV_CASC: cover property (cascade_match_irq_o);
  COV_LOW: cover property (low_match_irq_o && !cascade_match_irq_o);
  COV_SQ: cover property ($changed(square_wave_pin_o));
endmodule : casc_timer_chk
bind casc_timer casc_timer_chk u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .square_wave_pin_o(square_wave_pin_o),
  .low_match_irq_o(low_match_irq_o),
  .cascade_match_irq_o(cascade_match_irq_o));
`default_nettype wire

// >>> bench/ev_src.sv
// partner: pulse source on the event input pin
// assumes go, count and half width change after rising edges
`timescale 1ns/100ps
`default_nettype none
module ev_src (
  // clock and control
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       go_i,
  input  wire logic [9:0] n_i,
  input  wire logic [1:0] half_i,
  // pin and state
  output logic            pin_o,
  output logic            busy_o
);
  logic [9:0] left_r;  // pulses still owed
  logic [1:0] ph_r;    // cycles left in this half
  // each pulse rises then falls; pin idles low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      left_r <= '0;
      ph_r   <= '0;
      pin_o  <= 1'b0;
    end else if (go_i) begin
      left_r <= n_i;
      ph_r   <= half_i;
    end else if (ph_r != 2'h0) begin
      ph_r <= ph_r - 2'h1;
    end else if (left_r != 10'h0) begin
      pin_o  <= ~pin_o;
      ph_r   <= half_i;
      left_r <= left_r - {9'h0, pin_o};
    end
  end
  assign busy_o = (left_r != 10'h0);
endmodule : ev_src
`default_nettype wire

// >>> bench/tb_cascaded_timer_event_counter.sv
// bench: registers, event counting, internal clock periods
// assumes checker bound to the design, pulse partner below
`timescale 1ns/100ps
`default_nettype none
module tb_cascaded_timer_event_counter;
  import casc_timer_pkg::*;
  logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
  logic        go = 0, ack, sq, lo, ca, pin, busy;
  logic [4:0]  adr = '0;
  logic [31:0] wd = '0, rd, dat_o;
  logic [9:0]  np = '0;
  logic [1:0]  hp = 2'h1;
  logic [15:0] lf = 16'hd249;  // seed 53833
  logic [15:0] cm;
  logic [47:0] e;
  int          checks = 0, n_fail = 0, nlo = 0, nca = 0, l0, c0, t;
  logic        s0, f1 = 0, f2 = 0;
  initial forever #5 clk_i = ~clk_i;
  // match request tallies
  // every low and full request pulse is counted
  always @(posedge clk_i) begin
    nlo += int'(lo === 1'b1);
    nca += int'(ca === 1'b1);
  end
  casc_timer uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(wd), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .event_input_pin_i(pin), .square_wave_pin_o(sq),
    .low_match_irq_o(lo), .cascade_match_irq_o(ca));
  ev_src pulses (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .n_i(np),
    .half_i(hp), .pin_o(pin), .busy_o(busy));
  function automatic logic [15:0] nxt(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : nxt
  // expected low matches, full matches, final count
  function automatic logic [47:0] ev_model(logic [15:0] m, int p);
    logic [15:0] c = 0, l = 0, x = 0;
    repeat (p) begin
      if (c[7:0] == m[7:0]) l++;
      if (c == m) begin x++; c = 0; end else c++;
    end
    return {l, x, c};
  endfunction : ev_model
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] ex);
    checks++;
    if (seen !== ex) begin
      n_fail++;
      $display("unexpected %s exp %h seen %h", nm, ex, seen);
    end
  endtask : chk
  // one classic cycle; held until ack is sampled at an edge
  task automatic bus(logic w, logic [4:0] a, logic [31:0] d);
    int i = 0;
    @(posedge clk_i);
    cyc <= 1; stb <= 1; we <= w; adr <= a; wd <= d;
    do begin @(posedge clk_i); i++; end while (ack !== 1 && i < 50);
    rd = dat_o;
    cyc <= 0; stb <= 0;
    if (ack !== 1) begin n_fail++; wrap_up(); end
  endtask : bus
  // cycles between two full matches
  task automatic gap(output int n);
    int i = 0;
    do begin @(posedge clk_i); #1; i++; end while (ca !== 1 && i < 20000);
    if (ca !== 1) begin n_fail++; wrap_up(); end
    n = 0;
    do begin @(posedge clk_i); #1; n++; end while (ca !== 1 && n < 20000);
    if (ca !== 1) begin n_fail++; wrap_up(); end
  endtask : gap
  task automatic setup(logic [15:0] m, int code, int md);
    bus(1, OFS_MODE, 0);
    bus(1, OFS_CMP, 32'(m));
    bus(1, OFS_CLKSEL, 32'(code));
    bus(1, OFS_MODE, 32'(md));
  endtask : setup
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 0;
    for (int a = 0; a < 8; a++) begin
      bus(0, 5'(a * 4), 0);
      chk("reset value", rd, 0);
    end
    bus(1, OFS_COUNT, 32'h1234);
    bus(0, OFS_COUNT, 0);
    chk("count read only", rd, 0);
    $display("test done: registers");
    bus(1, OFS_OUTCTL, 32'h10);
    for (int k = 0; k < 4; k++) begin
      lf = nxt(lf); cm = lf & 16'h01ff;
      if (k == 0) cm = 16'h0;
      lf = nxt(lf);
      setup(cm, k & 1, 5);
      s0 = sq; l0 = nlo; c0 = nca;
      np <= 10'(20 + lf[8:0]); hp <= 2'(1 + lf[9]); go <= 1;
      @(posedge clk_i);
      go <= 0;
      // partner loads its count on this edge; look one edge later
      @(posedge clk_i);
      for (int i = 0; busy !== 0 && i < 5000; i++) @(posedge clk_i);
      if (busy !== 0) begin n_fail++; wrap_up(); end
      repeat (4) @(posedge clk_i);
      e = ev_model(cm, int'(np));
      chk("low matches", nlo - l0, e[47:32]);
      chk("full matches", nca - c0, e[31:16]);
      bus(0, OFS_COUNT, 0); // one word
      chk("count", rd, e[15:0]);
      chk("square pin", sq, s0 ^ e[16]);
      f1 = f1 ^ e[32];
      f2 = f2 ^ e[16];
    end
    // sticky flags set by the first run, then write-one clear
    bus(0, OFS_STAT, 0);
    chk("status", rd, {28'h0, f2, f1, 2'b11});
    bus(1, OFS_STAT, 32'h3);
    bus(0, OFS_STAT, 0);
    chk("status cleared", rd, {28'h0, f2, f1, 2'b00});
    $display("test done: event counting");
    for (int cd = 6; cd < 16; cd++) for (int dv = 0; dv < 2; dv++) begin
      lf = nxt(lf);
      bus(1, OFS_OSC, 32'(dv));
      setup({15'h0, lf[0]}, cd, 5);
      gap(t);
      chk("interval", t, (lf[0] + 1) << ((cd == 15 ? 11 : cd - 5)
        + (dv == 0)));
    end
    $display("test done: periods");
    for (int k = 0; k < 3; k++) begin
      setup(0, k ? 6 : 2, k == 1 ? 1 : k == 2 ? 4 : 5);
      c0 = nca;
      repeat (300) @(posedge clk_i);
      chk("no ticks", nca - c0, 0);
    end
    $display("test done: refused");
    setup(16'h00ff, 6, 5);
    repeat (300) @(posedge clk_i);
    c0 = nca;
    bus(1, OFS_CMP, 32'h10);
    repeat (200) @(posedge clk_i);
    bus(0, OFS_COUNT, 0);
    chk("wraps past", 32'(rd > 32'h96 && nca == c0), 1);
    bus(1, OFS_MODE, 0);
    bus(1, OFS_MODE, 5);
    gap(t);
    chk("restart interval", t, 34);
    $display("test done: compare change");
    wrap_up();
  end
  task automatic wrap_up();
    $display("checks %0d failures %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : wrap_up
endmodule : tb_cascaded_timer_event_counter
`default_nettype wire
